// file: core/pap_ahb_front.sv
// AHB-Lite slave front end, zero wait states, always OKAY
`timescale 1ns/1ps
`default_nettype none
module pap_ahb_front
  import pap_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // Register side
  pap_bus_if.front bus
);
  logic wr_pend;
  logic next_wr_pend;
  pap_idx_t wr_idx;
  pap_idx_t next_wr_idx;
  logic [31:0] next_hrdata;
  logic addr_ok;

  // Address phase acceptance and read strobe, data phase write strobe
  assign addr_ok = hsel_in & htrans_in[1] & hready_in;
  assign bus.rd_en = addr_ok & ~hwrite_in;
  assign bus.rd_idx = haddr_in[15:2];
  assign bus.wr_en = wr_pend & hready_in;
  assign bus.wr_idx = wr_idx;
  assign bus.wr_data = hwdata_in;

  // Next write pending and read data
  always_comb begin
    next_wr_pend = wr_pend;
    next_wr_idx = wr_idx;
    next_hrdata = hrdata_out;
    if (hready_in) begin
      next_wr_pend = addr_ok & hwrite_in;
      next_wr_idx = haddr_in[15:2];
    end
    if (bus.rd_en) begin
      next_hrdata = bus.rd_data;
    end
  end

  // Front end state
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_pend <= 1'b0;
      wr_idx <= 14'h0000;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata_out <= next_hrdata;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end
  end
endmodule : pap_ahb_front
`default_nettype wire

// file: core/pap_ingress_ctrl.sv
// Per-port ingress authentication, queue mapping and policer control bank
`timescale 1ns/1ps
`default_nettype none
`include "pap_regs.svh"
module pap_ingress_ctrl
  import pap_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // AHB-Lite slave
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic [2:0] hsize_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  // List state from the classifier
  input wire logic acl_list_enable_in,
  // Per-frame inputs
  input wire logic frame_valid_in,
  input wire logic [2:0] frame_prio_in,
  input wire logic frame_is_ip_in,
  input wire logic frame_srp_in,
  input wire pap_color_t dscp_color_in,
  input wire pap_color_t remap_color_in,
  input wire logic wred_drop_req_in,
  input wire logic pm_over_max_in,
  input wire logic pm_prob_drop_in,
  // Authentication decisions
  output logic auth_active_out,
  output logic miss_block_out,
  output logic miss_forward_out,
  output logic hit_list_action_out,
  output logic trap_to_host_out,
  // Indirect pointers
  output logic [2:0] port_index_out,
  output pap_queue_t queue_ptr_out,
  output logic [2:0] rate_port_out,
  output pap_queue_t rate_queue_out,
  // Per-frame results
  output logic frame_valid_out,
  output pap_queue_t frame_queue_out,
  output pap_color_t frame_color_out,
  output logic color_mark_out,
  output logic wred_drop_out,
  output logic pm_drop_out,
  // Policer settings
  output logic police_en_out,
  output logic color_blind_out,
  output logic per_port_police_out,
  output logic [1:0] perf_counter_sel_out,
  output logic count_dropped_only_out
);
  // -----------------------------------------------------------------
  // Bus front end
  // -----------------------------------------------------------------
  pap_bus_if bus ();

  pap_ahb_front u_front (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hwdata_in(hwdata_in),
    .hready_in(hready_in),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .bus(bus)
  );

  // -----------------------------------------------------------------
  // Register state
  // -----------------------------------------------------------------
  logic [1:0] auth_mode;
  logic [1:0] next_auth_mode;
  logic acl_seen;
  logic [2:0] port_index;
  logic [2:0] next_port_index;
  pap_queue_t queue_ptr;
  pap_queue_t next_queue_ptr;
  logic [15:0] prio_map;
  logic [15:0] next_prio_map;
  logic [15:0] map_from_bus;
  logic [31:0] map_word;
  logic [11:0] pol;
  logic [11:0] next_pol;
  logic [4:0] stat_word;

  // Word size is the only width used; hsize is accepted as is
  logic size_unused;
  assign size_unused = ^hsize_in;

  // Priority fields unpack from and pack into the map word
  genvar p;
  generate
    for (p = 0; p < 8; p++) begin : g_prio
      assign map_from_bus[2*p +: 2] = bus.wr_data[4*p +: 2];
      assign map_word[4*p +: 4] = {2'b00, next_prio_map[2*p +: 2]};
    end
  endgenerate

  // Register writes, reserved bits dropped
  always_comb begin
    next_auth_mode = auth_mode;
    next_port_index = port_index;
    next_queue_ptr = queue_ptr;
    next_prio_map = prio_map;
    next_pol = pol;
    if (bus.wr_en) begin
      case (bus.wr_idx)
        `PAP_IDX_AUTH: begin
          next_auth_mode = bus.wr_data[1:0];
        end
        `PAP_IDX_PTR: begin
          next_port_index = bus.wr_data[`PAP_PTR_PORT_LSB +: 3];
          next_queue_ptr = bus.wr_data[1:0];
        end
        `PAP_IDX_MAP: begin
          next_prio_map = map_from_bus;
        end
        `PAP_IDX_POL: begin
          next_pol = bus.wr_data[11:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Register flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auth_mode <= 2'h0;
      acl_seen <= 1'b0;
      port_index <= 3'h0;
      queue_ptr <= 2'h0;
      prio_map <= `PAP_MAP_RST;
      pol <= `PAP_POL_RST;
    end else begin
      auth_mode <= next_auth_mode;
      acl_seen <= acl_list_enable_in;
      port_index <= next_port_index;
      queue_ptr <= next_queue_ptr;
      prio_map <= next_prio_map;
      pol <= next_pol;
    end
  end

  // -----------------------------------------------------------------
  // Read mux, uses values after any write in the same cycle
  // -----------------------------------------------------------------
  assign stat_word = {acl_seen, trap_to_host_out, miss_forward_out, miss_block_out, auth_active_out};

  always_comb begin
    bus.rd_data = 32'h0000_0000;
    if (bus.rd_en) begin
      case (bus.rd_idx)
        `PAP_IDX_AUTH: begin
          bus.rd_data = {29'h0000_0000, acl_seen, next_auth_mode};
        end
        `PAP_IDX_PTR: begin
          bus.rd_data = {13'h0000, next_port_index, 14'h0000, next_queue_ptr};
        end
        `PAP_IDX_MAP: begin
          bus.rd_data = map_word;
        end
        `PAP_IDX_POL: begin
          bus.rd_data = {20'h0_0000, next_pol};
        end
        `PAP_IDX_STAT: begin
          bus.rd_data = {27'h000_0000, stat_word};
        end
        default: begin
          bus.rd_data = 32'h0000_0000;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Decoded control and per-frame results
  // -----------------------------------------------------------------
  logic next_auth_active;
  logic next_miss_block;
  logic next_miss_forward;
  logic next_hit_action;
  logic next_trap;
  logic [2:0] next_rate_port;
  logic next_frame_valid;
  pap_queue_t next_frame_queue;
  pap_color_t next_frame_color;
  logic next_color_mark;
  logic next_wred_drop;
  logic next_pm_drop;
  logic srp_ok;
  logic pm_cond;

  // Mode decode and frame handling
  always_comb begin
    next_auth_active = (auth_mode == `PAP_MODE_BLOCK) || (auth_mode == `PAP_MODE_TRAP);
    next_miss_block = acl_seen && next_auth_active;
    next_miss_forward = acl_seen && (auth_mode == `PAP_MODE_PASS);
    next_hit_action = acl_seen && (auth_mode != 2'h0);
    next_trap = (auth_mode == `PAP_MODE_TRAP);
    // Aggregate rates live under port zero
    next_rate_port = pol[`PAP_POL_PORT] ? port_index : 3'h0;
    next_frame_valid = frame_valid_in;
    next_frame_queue = prio_map[2*frame_prio_in +: 2];
    // Color selection for the policer
    if (!pol[`PAP_POL_EN] || pol[`PAP_POL_BLIND]) begin
      next_frame_color = `PAP_COLOR_GREEN;
    end else if (!frame_is_ip_in) begin
      next_frame_color = pol[`PAP_POL_NIP_LSB +: 2];
    end else if (pol[`PAP_POL_REMAP]) begin
      next_frame_color = remap_color_in;
    end else begin
      next_frame_color = dscp_color_in;
    end
    next_color_mark = frame_valid_in && pol[`PAP_POL_EN] && pol[`PAP_POL_MARK];
    // Reservation frames are protected unless allowed
    srp_ok = !frame_srp_in || pol[`PAP_POL_SRP];
    next_wred_drop = frame_valid_in && pol[`PAP_POL_EN] && wred_drop_req_in && srp_ok;
    pm_cond = pol[`PAP_POL_DROPALL] ? pm_over_max_in : pm_prob_drop_in;
    next_pm_drop = frame_valid_in && pol[`PAP_POL_EN] && pm_cond && srp_ok;
  end

  // Output flops
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auth_active_out <= 1'b0;
      miss_block_out <= 1'b0;
      miss_forward_out <= 1'b0;
      hit_list_action_out <= 1'b0;
      trap_to_host_out <= 1'b0;
      rate_port_out <= 3'h0;
      frame_valid_out <= 1'b0;
      frame_queue_out <= 2'h0;
      frame_color_out <= 2'h0;
      color_mark_out <= 1'b0;
      wred_drop_out <= 1'b0;
      pm_drop_out <= 1'b0;
    end else begin
      auth_active_out <= next_auth_active;
      miss_block_out <= next_miss_block;
      miss_forward_out <= next_miss_forward;
      hit_list_action_out <= next_hit_action;
      trap_to_host_out <= next_trap;
      rate_port_out <= next_rate_port;
      frame_valid_out <= next_frame_valid;
      frame_queue_out <= next_frame_queue;
      frame_color_out <= next_frame_color;
      color_mark_out <= next_color_mark;
      wred_drop_out <= next_wred_drop;
      pm_drop_out <= next_pm_drop;
    end
  end

  // Settings driven straight from register flops
  assign port_index_out = port_index;
  assign queue_ptr_out = queue_ptr;
  assign rate_queue_out = queue_ptr;
  assign police_en_out = pol[`PAP_POL_EN];
  assign color_blind_out = pol[`PAP_POL_BLIND];
  assign per_port_police_out = pol[`PAP_POL_PORT];
  assign perf_counter_sel_out = pol[`PAP_POL_SEL_LSB +: 2];
  assign count_dropped_only_out = pol[`PAP_POL_DROPCNT];
endmodule : pap_ingress_ctrl
`default_nettype wire

// file: pkg/pap_bus_if.sv
// Register access strobes between bus front end and register bank
`timescale 1ns/1ps
`default_nettype none
interface pap_bus_if;
  import pap_pkg::*;
  logic wr_en;
  pap_idx_t wr_idx;
  logic [31:0] wr_data;
  logic rd_en;
  pap_idx_t rd_idx;
  logic [31:0] rd_data;
  modport front (output wr_en, output wr_idx, output wr_data, output rd_en, output rd_idx, input rd_data);
  modport bank (input wr_en, input wr_idx, input wr_data, input rd_en, input rd_idx, output rd_data);
endinterface : pap_bus_if
`default_nettype wire

// file: pkg/pap_pkg.sv
// Shared types of the ingress auth/police bank
package pap_pkg;
  typedef logic [1:0] pap_color_t;
  typedef logic [1:0] pap_queue_t;
  typedef logic [13:0] pap_idx_t;
endpackage : pap_pkg

// file: pkg/pap_regs.svh
// Register offsets, field positions and reset values of the ingress auth/police bank
// Operation
// - Mode 01 blocks list misses, auth on
// - Mode 10 forwards list misses, auth off
// - Mode 11 traps all to host port
// - Bit 2 list enable, read-only, resets zero
// - Port index bits 18:16, eight ports
// - Queue pointer bits 1:0, four queues
// - Eight four-bit priority fields, queue in low bits
// - Reset map pairs priorities onto queues 0..3
// - Bit 0 enables policing and early discard
// - Bit 1 selects color blind over aware
// - Bit 2 lets discard drop reservation frames
// - Bit 3 remaps DSCP color when aware
// - Bit 4 marks color into DSCP field
// - Bits 6:5 non-IP frame color, reset 01
// - Bit 7 per-port policing, else port zero
// - Bits 9:8 select counter color statistic
// - Bit 10 drops all above memory maximum
// - Bit 11 counts only discarded frames
// - Rate entry addressed by queue and port
`ifndef PAP_REGS_SVH
`define PAP_REGS_SVH
// -----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// -----------------------------------------------------------------
`define PAP_IDX_AUTH 14'h0803
`define PAP_IDX_PTR 14'h0804
`define PAP_IDX_MAP 14'h0808
`define PAP_IDX_POL 14'h080C
`define PAP_IDX_STAT 14'h0810
// -----------------------------------------------------------------
// Field positions, codes and reset values
// -----------------------------------------------------------------
`define PAP_AUTH_ACL_BIT 2
`define PAP_MODE_BLOCK 2'h1
`define PAP_MODE_PASS 2'h2
`define PAP_MODE_TRAP 2'h3
`define PAP_PTR_PORT_LSB 16
`define PAP_MAP_RST 16'hFA50
`define PAP_POL_RST 12'h020
`define PAP_POL_EN 0
`define PAP_POL_BLIND 1
`define PAP_POL_SRP 2
`define PAP_POL_REMAP 3
`define PAP_POL_MARK 4
`define PAP_POL_NIP_LSB 5
`define PAP_POL_PORT 7
`define PAP_POL_SEL_LSB 8
`define PAP_POL_DROPALL 10
`define PAP_POL_DROPCNT 11
`define PAP_COLOR_GREEN 2'h1
`endif

// file: verification/pap_ingress_checker.sv
// Port assertions of the ingress auth/police bank
`timescale 1ns/1ps
`default_nettype none
`include "pap_regs.svh"
module pap_ingress_checker
  import pap_pkg::*;
(
  // Clock, reset, bus
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  // Frame and list inputs
  input wire logic acl_list_enable_in,
  input wire logic frame_valid_in,
  input wire logic frame_srp_in,
  input wire logic wred_drop_req_in,
  // Outputs under watch
  input wire logic miss_block_out,
  input wire logic miss_forward_out,
  input wire logic hit_list_action_out,
  input wire logic [2:0] port_index_out,
  input wire pap_queue_t queue_ptr_out,
  input wire logic [2:0] rate_port_out,
  input wire pap_queue_t rate_queue_out,
  input wire logic frame_valid_out,
  input wire pap_color_t frame_color_out,
  input wire logic wred_drop_out,
  input wire logic pm_drop_out,
  input wire logic police_en_out,
  input wire logic color_blind_out,
  input wire logic per_port_police_out,
  input wire logic [1:0] perf_counter_sel_out,
  input wire logic count_dropped_only_out
);
  // ----------
  // Assertions
  // ----------
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Accepted write to one index, then its data phase
  sequence wr_s(idx);
    hsel_in && htrans_in[1] && hready_in && hwrite_in && haddr_in[15:2] == idx ##1 hready_in;
  endsequence
  police_write_a: assert property (wr_s(`PAP_IDX_POL) |=>
    {count_dropped_only_out, perf_counter_sel_out, per_port_police_out, color_blind_out, police_en_out} ==
    {$past(hwdata_in[11]), $past(hwdata_in[9:7]), $past(hwdata_in[1:0])}) else $error("police bits wrong");
  pointer_write_a: assert property (wr_s(`PAP_IDX_PTR) |=>
    {port_index_out, queue_ptr_out} == {$past(hwdata_in[18:16]), $past(hwdata_in[1:0])}) else $error("pointer wrong");
  rate_port_a: assert property (1'b1 |=>
    rate_port_out == ($past(per_port_police_out) ? $past(port_index_out) : 3'h0)) else $error("rate port wrong");
  rate_queue_a: assert property (rate_queue_out == queue_ptr_out) else $error("rate queue wrong");
  frame_valid_a: assert property (1'b1 |=>
    frame_valid_out == $past(frame_valid_in)) else $error("frame valid late");
  wred_drop_a: assert property (frame_valid_in && police_en_out && wred_drop_req_in && !frame_srp_in |=>
    wred_drop_out) else $error("discard missing");
  wred_quiet_a: assert property (!(frame_valid_in && police_en_out && wred_drop_req_in) |=>
    !wred_drop_out) else $error("discard unasked");
  pm_quiet_a: assert property (!(frame_valid_in && police_en_out) |=> !pm_drop_out)
    else $error("memory drop unasked");
  blind_color_a: assert property (frame_valid_in && (!police_en_out || color_blind_out) |=>
    frame_color_out == 2'h1) else $error("blind color wrong");
  acl_gate_a: assert property (miss_block_out || miss_forward_out || hit_list_action_out |->
    $past(acl_list_enable_in, 2)) else $error("list decision without list");
endmodule : pap_ingress_checker
bind pap_ingress_ctrl pap_ingress_checker chk_u (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
  .hwdata_in, .hready_in, .acl_list_enable_in, .frame_valid_in, .frame_srp_in, .wred_drop_req_in, .miss_block_out,
  .miss_forward_out, .hit_list_action_out, .port_index_out, .queue_ptr_out, .rate_port_out, .rate_queue_out,
  .frame_valid_out, .frame_color_out, .wred_drop_out, .pm_drop_out, .police_en_out, .color_blind_out,
  .per_port_police_out, .perf_counter_sel_out, .count_dropped_only_out);
`default_nettype wire

// file: verification/pap_ingress_ctrl_tb.sv
// Self-checking bench of the ingress auth/police bank
`timescale 1ns/1ps
`default_nettype none
`include "pap_regs.svh"
module pap_ingress_ctrl_tb
  import pap_pkg::*;
;
  logic clk_in = 1'b0, rst_in = 1'b1, hsel_in = 1'b0, hwrite_in = 1'b0, acl_list_enable_in = 1'b0;
  logic [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, hrdata_out, rd, wd, fr, pv, seed;
  logic [1:0] htrans_in = 2'h0, perf_counter_sel_out;
  logic [2:0] hsize_in = 3'h2, frame_prio_in = 3'h0, port_index_out, rate_port_out;
  logic frame_valid_in = 1'b0, frame_is_ip_in = 1'b0, frame_srp_in = 1'b0, wred_drop_req_in = 1'b0;
  logic pm_over_max_in = 1'b0, pm_prob_drop_in = 1'b0, hreadyout_out, hresp_out, auth_active_out;
  logic miss_block_out, miss_forward_out, hit_list_action_out, trap_to_host_out, frame_valid_out;
  logic color_mark_out, wred_drop_out, pm_drop_out, police_en_out, color_blind_out;
  logic per_port_police_out, count_dropped_only_out;
  pap_color_t dscp_color_in = 2'h0, remap_color_in = 2'h0, frame_color_out;
  pap_queue_t queue_ptr_out, rate_queue_out, frame_queue_out;
  int fails = 0, checks_done = 0, k;
  // Register table: index, writable mask, reset value; last entry unmapped
  pap_idx_t idx[5] = '{`PAP_IDX_AUTH, `PAP_IDX_PTR, `PAP_IDX_MAP, `PAP_IDX_POL, 14'h0900};
  logic [31:0] msk[5] = '{32'h0000_0003, 32'h0007_0003, 32'h3333_3333, 32'h0000_0fff, 32'h0};
  logic [31:0] rst_v[5] = '{32'h0, 32'h0, 32'h3322_1100, 32'h0000_0020, 32'h0};
  logic [31:0] sh[5];

  pap_ingress_ctrl dut_u (.hready_in(hreadyout_out), .*);

  // Clock, 8 ns period
  initial forever #4 clk_in = ~clk_in;

  // ---------------
  // Shared tasks
  // ---------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  // One single AHB transfer, waits on hready in both phases
  task automatic bus(input logic wr, input pap_idx_t i, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {16'h0, i, 2'b00};
    hwrite_in <= wr;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
    check(hresp_out, 32'h0);
  endtask : bus

  task automatic reset_check;
    rst_in <= 1'b1;
    acl_list_enable_in <= 1'b0;
    frame_valid_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check({police_en_out, color_blind_out, per_port_police_out, port_index_out, queue_ptr_out}, 0);
    for (int j = 0; j < 5; j++) begin
      sh[j] = rst_v[j];
      bus(1'b0, idx[j], 32'h0);
      check(rd, rst_v[j]);
    end
  endtask : reset_check

  // Expected decisions: active, miss block, miss forward, list hit, trap
  function automatic logic [4:0] exp_auth(input logic [1:0] m, input logic a);
    return {m[0], a & m[0], a & (m == 2'h2), a & (m != 2'h0), m == 2'h3};
  endfunction : exp_auth

  // Expected frame result from {valid, prio, ip, srp, dscp, remap, req, over, prob}
  function automatic logic [7:0] exp_frame(input logic [31:0] f, input logic [31:0] m, input logic [31:0] p);
    logic ok;
    pap_color_t c;
    ok = !f[7] | p[2];
    c = (!p[0] || p[1]) ? 2'h1 : !f[8] ? p[6:5] : p[3] ? f[4:3] : f[6:5];
    return {f[12], f[12] & p[0] & f[2] & ok, f[12] & p[0] & (p[10] ? f[1] : f[0]) & ok, f[12] & p[0] & p[4],
      f[12] ? {m[f[11:9] * 4 +: 2], c} : 4'h0};
  endfunction : exp_frame

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  // Watchdog against a hung handshake
  initial begin
    #200000;
    fails++;
    conclude();
  end

  // ---------------
  // Main sequence
  // ---------------
  initial begin
    seed = $urandom(89);
    reset_check();
    // Random register writes, readback and direct outputs
    for (int i = 0; i < 40; i++) begin
      k = $urandom_range(4);
      wd = $urandom;
      sh[k] = wd & msk[k];
      bus(1'b1, idx[k], wd);
      bus(1'b0, idx[k], 32'h0);
      check(rd, sh[k]);
      check({count_dropped_only_out, perf_counter_sel_out, per_port_police_out, color_blind_out, police_en_out},
        {sh[3][11], sh[3][9:7], sh[3][1:0]});
      check({port_index_out, queue_ptr_out, rate_queue_out}, {sh[1][18:16], sh[1][1:0], sh[1][1:0]});
      check(rate_port_out, sh[3][7] ? sh[1][18:16] : 3'h0);
    end
    // Every mode with the list off and on, bit 2 written at random
    for (int m = 0; m < 8; m++) begin
      acl_list_enable_in <= m[2];
      wd = $urandom;
      wd[1:0] = m[1:0];
      bus(1'b1, `PAP_IDX_AUTH, wd);
      bus(1'b0, `PAP_IDX_AUTH, 32'h0);
      check(rd, {29'h0, m[2], m[1:0]});
      check({auth_active_out, miss_block_out, miss_forward_out, hit_list_action_out, trap_to_host_out},
        exp_auth(m[1:0], m[2]));
      // Status word mirrors the decoded levels and the list bit
      bus(1'b0, `PAP_IDX_STAT, 32'h0);
      check(rd, {m[2], m[1:0] == 2'h3, m[2] & (m[1:0] == 2'h2), m[2] & m[0], m[0]});
    end
    // Random frames under random map and police settings
    for (int r = 0; r < 5; r++) begin
      sh[2] = $urandom & msk[2];
      sh[3] = ($urandom & msk[3]) | (r != 0);
      bus(1'b1, `PAP_IDX_MAP, sh[2]);
      bus(1'b1, `PAP_IDX_POL, sh[3]);
      for (int i = 0; i <= 40; i++) begin
        pv = fr;
        fr = $urandom;
        {frame_valid_in, frame_prio_in, frame_is_ip_in, frame_srp_in, dscp_color_in, remap_color_in,
          wred_drop_req_in, pm_over_max_in, pm_prob_drop_in} <= fr[12:0];
        #1;
        if (i > 0) check({frame_valid_out, wred_drop_out, pm_drop_out, color_mark_out,
          frame_valid_out === 1'b1 ? {frame_queue_out, frame_color_out} : 4'h0},
          exp_frame(pv, sh[2], sh[3]));
        @(posedge clk_in);
      end
    end
    // Reset again at the end of the run, with settings away from their defaults
    reset_check();
    conclude();
  end
endmodule : pap_ingress_ctrl_tb
`default_nettype wire
